// ===== pump_sup_pkg.sv
// Purpose: shared constants and types for the pump alternator and fault supervisor
// Assumes: 40 MHz clk_sys, registers on an apb slave, pins filtered on entry
// Notes:   delays counted in millisecond ticks from one divider, except the run verify delay, counted in clocks
// =============================================================
// Summary of operation
// - with alternation on, advance the alternator on every pump start
// - a pump that fails to start hands lead to the next available pump
// - pumps out of auto are skipped; the others keep alternating
// - alternation modes: all pumps, pumps 1-2, pumps 2-3, or none
// - with alternation on, new lead is the next pump in ascending order
// - without alternation pump 1 leads, pump 2 first lag, pump 3 second lag
// - starters not used for pumping follow the override control points
// - the external monitor holds the phase input closed; open means fault
// - three run inputs, each checking the starter of the same pump
// - missing run status: pump off, starter alarm, start the next pump
// - a starter drives its coil when energized or its selector is in hand
// - auxiliary pair is a delay relay; zero delay makes both plain points
// - on-delay: output only after trigger held longer than the delay
// - with delay off, count auxiliary pulses of at least 25 ms
// - alarm light and horn on only while an alarm condition exists
// - alarm conditions reported to telemetry; alarm outputs can be disabled
// - horn silenced by switch, telemetry or input; new alarm resounds it
// - failed pump retried after a delay if enabled, else skipped
// - phase loss, high, low and sequence faults reported separately
// - phase fault blocks automatic starters and drives both alarms
// - transducer fault falls back to floats, second transducer or timer
// - pump-down: lead starts above lead level, stops below lead-off level
package pump_sup_pkg;
    // =============================================================
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS         = 1_000_000;
    localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
    localparam logic [15:0] PULSE_MIN_MS = 16'h0019;
    localparam int DEBOUNCE_MS   = 5;
    localparam int NPUMP         = 3;
    localparam int NFILT         = 17;
    // =============================================================
    // register offsets
    localparam logic [7:0] A_CTRL    = 8'h00;
    localparam logic [7:0] A_AUXDLY  = 8'h04;
    localparam logic [7:0] A_RETRY   = 8'h08;
    localparam logic [7:0] A_VERIFY  = 8'h0c;
    localparam logic [7:0] A_RUNTIME = 8'h10;
    localparam logic [7:0] A_STATUS  = 8'h14;
    localparam logic [7:0] A_PULSES  = 8'h18;
    localparam logic [7:0] A_SILENCE = 8'h1c;
    // =============================================================
    // reset values
    localparam logic [14:0] CTRL_RST    = 15'h7008;
    localparam logic [15:0] AUXDLY_RST  = 16'h0000;
    localparam logic [15:0] RETRY_RST   = 16'h03e8;
    localparam logic [15:0] VERIFY_RST  = 16'h0fa0;
    localparam logic [15:0] RUNTIME_RST = 16'h2710;
    // =============================================================
    // types
    typedef enum logic [1:0] {ALT_ALL, ALT_12, ALT_23, ALT_NONE} alt_mode_t;
    typedef enum logic [1:0] {FB_FLOAT, FB_XDCR2, FB_FLOATSET, FB_TIMER} fb_mode_t;
    typedef struct packed {
        logic [2:0] used;
        fb_mode_t   fb;
        logic       aux_tlm;
        logic [2:0] ovr;
        logic       aux_trig;
        logic       aux_ondly;
        logic       alarm_en;
        logic       retry_en;
        alt_mode_t  alt;
    } ctrl_t;
    typedef struct packed {
        logic above_lead;
        logic below_stop;
        logic high;
        logic low;
    } lvl_t;
    typedef struct packed {
        logic seq;
        logic lo_v;
        logic hi_v;
        logic loss;
    } phase_t;
endpackage

// ===== input_filter.sv
// Purpose: three-flop synchroniser and tick-based debounce per input bit
// Assumes: tick is a one-cycle enable pulse
// Notes:   a bit changes after STABLE ticks of agreement
`timescale 1ns/1ps
module input_filter #(
    parameter int W      = 16,
    parameter int STABLE = 5
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         tick,
    // pins
    input  wire logic [W-1:0] raw,
    output logic      [W-1:0] clean
);
    localparam int CW = $clog2(STABLE + 1);
    // =============================================================
    // per bit filter
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        logic [2:0]    s_r;
        logic [CW-1:0] cnt_r;
        always_ff @(posedge clk_sys)
            s_r <= rst ? 3'h0 : {s_r[1:0], raw[i]};
        always_ff @(posedge clk_sys)
        begin
            if (rst || s_r[1] != s_r[2] || s_r[2] == clean[i])
                cnt_r <= '0;
            else if (tick && cnt_r == CW'(STABLE - 1))
                cnt_r <= '0;
            else if (tick)
                cnt_r <= cnt_r + 1'b1;
        end
        always_ff @(posedge clk_sys)
        begin
            if (rst)
                clean[i] <= 1'b0;
            else if (tick && s_r[1] == s_r[2] && cnt_r == CW'(STABLE - 1))
                clean[i] <= s_r[2];
        end
    end
endmodule

// ===== pump_supervisor.sv
// Purpose: lead/lag alternator, run verification, phase, aux relay and alarms
// Assumes: apb slave on clk_sys; phase causes and transducers are same-clock
// Notes:   one wait state on every apb access
`timescale 1ns/1ps
module pump_supervisor
    import pump_sup_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pump pins
    input  wire logic        pump1_run_in,
    input  wire logic        pump2_run_in,
    input  wire logic        pump3_run_in,
    input  wire logic [2:0]  hand_in,
    input  wire logic [2:0]  auto_in,
    output logic             pump1_starter_out,
    output logic             pump2_starter_out,
    output logic             pump3_starter_out,
    // phase and level
    input  wire logic        phase_ok_in,
    input  wire phase_t      phase_cause,
    input  wire lvl_t        float_in,
    input  wire lvl_t        xdcr1,
    input  wire lvl_t        xdcr2,
    input  wire logic        xdcr_fault,
    input  wire logic        internal_fault,
    // aux and alarm
    input  wire logic        aux_in,
    input  wire logic        silence_sw_in,
    input  wire logic        ext_silence_in,
    output logic             aux_out,
    output logic             alarm_light_out,
    output logic             alarm_horn_out
);
    typedef enum logic [1:0] {ST_IDLE, ST_VERIFY, ST_RUN} seq_t;

    function automatic logic [1:0] inc(input logic [1:0] p);
        inc = (p == 2'd2) ? 2'd0 : p + 2'd1;
    endfunction

    function automatic logic [2:0] dec(input logic [1:0] p);
        dec = 3'h1 << p;
    endfunction

    function automatic logic [2:0] ring(input alt_mode_t m);
        unique case (m)
            ALT_12:  ring = 3'h3;
            ALT_23:  ring = 3'h6;
            default: ring = 3'h7;
        endcase
    endfunction

    function automatic logic [1:0] pick(input logic [1:0] cur, input alt_mode_t m,
                                        input logic [2:0] av);
        logic [1:0] p;
        logic [2:0] ok;
        logic       hit;
        ok   = av & ring(m);
        p    = (m == ALT_NONE) ? 2'd0 : inc(cur);
        hit  = 1'b0;
        pick = cur;
        for (int k = 0; k < 3; k++)
        begin
            if (!hit && ok[p])
            begin
                pick = p;
                hit  = 1'b1;
            end
            p = inc(p);
        end
    endfunction

    // =============================================================
    // millisecond tick
    logic [31:0] div_r;
    logic        tick_r;
    always_ff @(posedge clk_sys)
    begin
        if (rst || div_r == 32'(MS_CYCLES - 1))
            div_r <= 32'h0;
        else
            div_r <= div_r + 32'h1;
    end
    always_ff @(posedge clk_sys)
        tick_r <= !rst && div_r == 32'(MS_CYCLES - 1);

    // =============================================================
    // input filtering
    logic [NFILT-1:0] flt;
    logic [2:0]       run_f, hand_f, auto_f;
    logic             phok_f, aux_f, sil_f, esil_f;
    lvl_t             fl_f;
    input_filter #(.W(NFILT), .STABLE(DEBOUNCE_MS)) u_filt (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tick    (tick_r),
        .raw     ({float_in, ext_silence_in, silence_sw_in, aux_in, phase_ok_in,
                   auto_in, hand_in, pump3_run_in, pump2_run_in, pump1_run_in}),
        .clean   (flt)
    );
    assign {fl_f, esil_f, sil_f, aux_f, phok_f, auto_f, hand_f, run_f} = flt;

    // =============================================================
    // registers
    ctrl_t       ctrl_r;
    logic [15:0] auxdly_r, retry_r, verify_r, runtime_r, pulses_r;
    logic        tlm_sil_r;
    logic        wr_ok, acc;
    assign acc   = psel && penable && pready;
    assign wr_ok = acc && pwrite;
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctrl_r    <= ctrl_t'(CTRL_RST);
            auxdly_r  <= AUXDLY_RST;
            retry_r   <= RETRY_RST;
            verify_r  <= VERIFY_RST;
            runtime_r <= RUNTIME_RST;
        end
        else if (wr_ok)
        begin
            unique case (paddr)
                A_CTRL:    ctrl_r    <= ctrl_t'(pwdata[14:0]);
                A_AUXDLY:  auxdly_r  <= pwdata[15:0];
                A_RETRY:   retry_r   <= pwdata[15:0];
                A_VERIFY:  verify_r  <= pwdata[15:0];
                A_RUNTIME: runtime_r <= pwdata[15:0];
                default:   ;
            endcase
        end
    end
    always_ff @(posedge clk_sys)
        tlm_sil_r <= !rst && wr_ok && paddr == A_SILENCE;

    // =============================================================
    // level source and demand
    lvl_t        lv;
    logic        demand_r;
    logic [15:0] tmr_r;
    always_comb
    begin
        lv = xdcr1;
        if (xdcr_fault)
        begin
            unique case (ctrl_r.fb)
                FB_FLOAT:    lv = '{fl_f.high, fl_f.low, fl_f.high, fl_f.low};
                FB_XDCR2:    lv = xdcr2;
                FB_FLOATSET: lv = fl_f;
                FB_TIMER:    lv = '{fl_f.high, fl_f.low || tmr_r >= runtime_r,
                                    fl_f.high, fl_f.low};
            endcase
        end
    end
    always_ff @(posedge clk_sys)
    begin
        if (rst || lv.below_stop || lv.low)
            demand_r <= 1'b0;
        else if (lv.above_lead)
            demand_r <= 1'b1;
    end
    // run timer counts while demand is on in every fallback mode, read only by timer fallback; rearms when demand drops
    always_ff @(posedge clk_sys)
    begin
        if (rst || !demand_r)
            tmr_r <= 16'h0;
        else if (tick_r && tmr_r != 16'hffff)
            tmr_r <= tmr_r + 16'h1;
    end

    // =============================================================
    // phase
    logic phase_fault;
    assign phase_fault = !phok_f || (|phase_cause);

    // =============================================================
    // sequencer
    seq_t        st_r;
    logic [1:0]  lead_r;
    logic [15:0] vcnt_r;
    logic [2:0]  fail_r, avail, others;
    logic        start_ev, check, fail_ev, run_ok;
    assign avail    = auto_f & ~fail_r & ctrl_r.used;
    assign others   = avail & ~dec(lead_r) & ring(ctrl_r.alt);
    assign run_ok   = demand_r && !phase_fault;
    assign start_ev = st_r == ST_IDLE && run_ok && |(avail & ring(ctrl_r.alt));
    assign check    = st_r == ST_VERIFY && run_ok && vcnt_r == 16'h0;
    assign fail_ev  = check && !run_f[lead_r];
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_r   <= ST_IDLE;
            lead_r <= 2'd0;
            vcnt_r <= 16'h0;
        end
        else
        begin
            unique case (st_r)
                ST_IDLE:
                    if (start_ev)
                    begin
                        lead_r <= pick(lead_r, ctrl_r.alt, avail);
                        vcnt_r <= verify_r;
                        st_r   <= ST_VERIFY;
                    end
                ST_VERIFY:
                    if (!run_ok)
                        st_r <= ST_IDLE;
                    else if (fail_ev)
                    begin
                        lead_r <= pick(lead_r, ctrl_r.alt, others);
                        vcnt_r <= verify_r;
                        st_r   <= (|others) ? ST_VERIFY : ST_IDLE;
                    end
                    else if (check)
                        st_r <= ST_RUN;
                    else
                        vcnt_r <= vcnt_r - 16'h1;
                ST_RUN:
                    if (!run_ok)
                        st_r <= ST_IDLE;
            endcase
        end
    end

    // =============================================================
    // failed pumps
    for (genvar i = 0; i < NPUMP; i++)
    begin : g_fail
        logic [15:0] rcnt_r;
        always_ff @(posedge clk_sys)
        begin
            if (rst || !fail_r[i])
                rcnt_r <= 16'h0;
            else if (tick_r && rcnt_r != 16'hffff)
                rcnt_r <= rcnt_r + 16'h1;
        end
        // retry or skip until out of auto; a new failure wins
        always_ff @(posedge clk_sys)
        begin
            if (rst)
                fail_r[i] <= 1'b0;
            else if (fail_ev && lead_r == 2'(i))
                fail_r[i] <= 1'b1;
            else if (!auto_f[i] || (ctrl_r.retry_en && rcnt_r >= retry_r))
                fail_r[i] <= 1'b0;
        end
    end

    // =============================================================
    // starters
    logic [2:0] auto_cmd, str_r;
    // high level brings in every available pump at once
    assign auto_cmd = ((st_r != ST_IDLE) ? dec(lead_r) : 3'h0)
                    | ((lv.high && run_ok) ? avail : 3'h0);
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            str_r <= 3'h0;
        else
            str_r <= hand_f | (auto_cmd & ctrl_r.used & {3{!phase_fault}})
                   | (ctrl_r.ovr & ~ctrl_r.used);
    end
    assign {pump3_starter_out, pump2_starter_out, pump1_starter_out} = str_r;

    // =============================================================
    // alarms
    logic [3:0] cond, cond_d_r;
    logic       horn_r, light_r, hout_r, silence;
    assign cond    = {internal_fault || xdcr_fault || (|fail_r), lv.low, lv.high,
                      phase_fault};
    assign silence = sil_f || esil_f || tlm_sil_r;
    always_ff @(posedge clk_sys)
        cond_d_r <= rst ? 4'h0 : cond;
    // new condition beats a silence in the same cycle
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            horn_r <= 1'b0;
        else if (|(cond & ~cond_d_r))
            horn_r <= 1'b1;
        else if (silence)
            horn_r <= 1'b0;
    end
    always_ff @(posedge clk_sys)
    begin
        light_r <= !rst && ctrl_r.alarm_en && |cond;
        hout_r  <= !rst && ctrl_r.alarm_en && |cond && horn_r;
    end
    assign alarm_light_out = light_r;
    assign alarm_horn_out  = hout_r;

    // =============================================================
    // auxiliary relay and pulse counter
    logic [15:0] acnt_r;
    logic        trig, aux_d_r, aux_r, dly_off;
    assign dly_off = auxdly_r == 16'h0;
    assign trig    = dly_off ? aux_f : (aux_f == ctrl_r.aux_trig);
    always_ff @(posedge clk_sys)
    begin
        if (rst || !trig)
            acnt_r <= 16'h0;
        else if (tick_r && acnt_r != 16'hffff)
            acnt_r <= acnt_r + 16'h1;
    end
    always_ff @(posedge clk_sys)
        aux_d_r <= rst ? 1'b0 : aux_f;
    // count wide pulses on the falling edge
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            pulses_r <= 16'h0;
        else if (dly_off && aux_d_r && !aux_f && acnt_r >= PULSE_MIN_MS)
            pulses_r <= pulses_r + 16'h1;
    end
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            aux_r <= 1'b0;
        else if (dly_off)
            aux_r <= ctrl_r.aux_tlm;
        else if (ctrl_r.aux_ondly)
            aux_r <= trig && acnt_r > auxdly_r;
        else
            aux_r <= trig;
    end
    assign aux_out = aux_r;

    // =============================================================
    // apb read and handshake
    logic [31:0] rd, prdata_r;
    logic        pready_r, pslverr_r, hit;
    always_comb
    begin
        rd  = 32'h0;
        hit = 1'b1;
        unique case (paddr)
            A_CTRL:    rd = {17'h0, ctrl_r};
            A_AUXDLY:  rd = {16'h0, auxdly_r};
            A_RETRY:   rd = {16'h0, retry_r};
            A_VERIFY:  rd = {16'h0, verify_r};
            A_RUNTIME: rd = {16'h0, runtime_r};
            A_STATUS:  rd = {12'h0, xdcr_fault, str_r, aux_r, hout_r, cond,
                             !phok_f, phase_cause, fail_r, lead_r};
            A_PULSES:  rd = {16'h0, pulses_r};
            A_SILENCE: rd = 32'h0;
            default:   hit = 1'b0;
        endcase
    end
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end
        else
        begin
            pready_r  <= psel && penable && !pready_r;
            pslverr_r <= psel && penable && !pready_r && !hit;
            if (psel && penable && !pready_r && !pwrite)
                prdata_r <= rd;
        end
    end
    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // =============================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_fail;
        st_r == ST_VERIFY && run_ok && vcnt_r == 16'h0 && !run_f[lead_r];
    endsequence
    property p_verify_fail;
        s_fail |=> fail_r[$past(lead_r)] ##1 !str_r[$past(lead_r, 2)];
    endproperty
    a_verify_fail: assert property (p_verify_fail) else $error("failed pump kept");
    property p_hand;
        hand_f[2] |=> pump3_starter_out;
    endproperty
    a_hand: assert property (p_hand) else $error("hand not honoured");
    property p_phase_block;
        phase_fault && !hand_f[1] && ctrl_r.used[1] |=> !pump2_starter_out;
    endproperty
    a_phase_block: assert property (p_phase_block) else $error("start in phase fault");
    property p_quiet;
        !(|cond) |=> !alarm_light_out && !alarm_horn_out;
    endproperty
    a_quiet: assert property (p_quiet) else $error("alarm with no cause");
    property p_alarm_en;
        !ctrl_r.alarm_en |=> !alarm_light_out;
    endproperty
    a_alarm_en: assert property (p_alarm_en) else $error("light not disabled");
    property p_alt_all;
        start_ev && ctrl_r.alt == ALT_ALL && &avail |=> lead_r == inc($past(lead_r));
    endproperty
    a_alt_all: assert property (p_alt_all) else $error("lead not next");
    property p_alt_none;
        start_ev && ctrl_r.alt == ALT_NONE && avail[0] |=> lead_r == 2'd0;
    endproperty
    a_alt_none: assert property (p_alt_none) else $error("pump 1 not lead");
    property p_ondly;
        !dly_off && ctrl_r.aux_ondly && !trig |=> !aux_out;
    endproperty
    a_ondly: assert property (p_ondly) else $error("aux early");
    property p_pulse;
        $changed(pulses_r) |-> $past(acnt_r) >= PULSE_MIN_MS && $past(dly_off);
    endproperty
    a_pulse: assert property (p_pulse) else $error("short pulse counted");
endmodule

// ===== pump_field.sv
// Purpose: far-side model: starter coils, run contacts, phase monitor
// Assumes: contacts follow the coil at once
// Notes:   fail mask holds a contact open
`timescale 1ns/1ps
module pump_field
(
    // coils and selectors
    input  wire logic [2:0] starter,
    input  wire logic [2:0] hand,
    input  wire logic [2:0] fail,
    input  wire logic       trip,
    // contacts
    output logic      [2:0] run,
    output logic            phase_ok
);
    assign run = (starter | hand) & ~fail;
    assign phase_ok = ~trip;
endmodule

// ===== pump_alternator_fault_supervisor_tb.sv
// Purpose: self-checking bench for pump_supervisor
// Assumes: MS_CYCLES shortened to 10
// Notes:   levels driven through the first transducer
`timescale 1ns/1ps
module pump_alternator_fault_supervisor_tb;
    import pump_sup_pkg::*;
    // =============================================================
    // signals
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0]  run, st, hand = 3'h0, auto = 3'h7, fail = 3'h0;
    logic        trip = 1'b0, phase_ok, light, horn, sil = 1'b0, aux = 1'b0, ao;
    lvl_t        lvl = 4'h0;
    int          n_fail = 0, cmp_count = 0, cyc = 0;

    pump_field field (.starter(st), .hand(hand), .fail(fail), .trip(trip), .run(run),
        .phase_ok(phase_ok));
    pump_supervisor #(.MS_CYCLES(10)) dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pump1_run_in(run[0]), .pump2_run_in(run[1]),
        .pump3_run_in(run[2]), .hand_in(hand), .auto_in(auto), .pump1_starter_out(st[0]),
        .pump2_starter_out(st[1]), .pump3_starter_out(st[2]), .phase_ok_in(phase_ok),
        .phase_cause(4'h0), .float_in(lvl), .xdcr1(lvl), .xdcr2(lvl), .xdcr_fault(1'b0),
        .internal_fault(1'b0), .aux_in(aux), .silence_sw_in(sil), .ext_silence_in(1'b0),
        .aux_out(ao), .alarm_light_out(light), .alarm_horn_out(horn));

    always #12.5 clk_sys = ~clk_sys;
    // hang guard
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_fail++;
            results();
        end
    end
    // =============================================================
    // shared tasks
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // filtered pins take tens of clocks, so poll
    task wt(input logic [4:0] m, input logic [4:0] e, input string n);
        for (int i = 0; i < 300 && (({light, horn, st} & m) !== e); i++) @(posedge clk_sys);
        chk(n, 32'(e), 32'({light, horn, st} & m));
    endtask
    // =============================================================
    // scenarios
    task t_regs;
        apb(1'b0, A_CTRL, 32'h0);
        chk("ctrl reset", {17'h0, CTRL_RST}, rd);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
    endtask
    task t_fixed;
        apb(1'b1, A_CTRL, 32'h700b);
        apb(1'b1, A_VERIFY, 32'h64);
        lvl <= 4'h8;
        wt(5'h07, 5'h01, "fixed lead");
        lvl <= 4'h4;
        wt(5'h07, 5'h00, "lead stop");
    endtask
    task t_alt;
        logic [2:0] p;
        apb(1'b1, A_CTRL, 32'h7008);
        lvl <= 4'h8;
        repeat (300) if (st === 3'h0) @(posedge clk_sys);
        p = st;
        lvl <= 4'h4;
        wt(5'h07, 5'h00, "alt stop");
        lvl <= 4'h8;
        wt(5'h07, {2'h0, p[1:0], p[2]}, "next lead");
        lvl <= 4'h4;
        wt(5'h07, 5'h00, "alt stop");
    endtask
    task t_fail;
        apb(1'b1, A_CTRL, 32'h700b);
        fail <= 3'h1;
        lvl <= 4'h8;
        wt(5'h07, 5'h02, "fail over");
        apb(1'b0, A_STATUS, 32'h0);
        chk("starter alarm", 32'h1, {29'h0, rd[4:2]});
        fail <= 3'h0;
    endtask
    task t_phase;
        trip <= 1'b1;
        hand <= 3'h4;
        wt(5'h1f, 5'h1c, "phase fault");
        sil <= 1'b1;
        wt(5'h18, 5'h10, "silenced");
        sil <= 1'b0;
        // let the filtered silence fall first, a held silence mutes the horn
        repeat (100) @(posedge clk_sys);
        lvl <= 4'ha;
        wt(5'h18, 5'h18, "resound");
    endtask
    task t_aux;
        apb(1'b1, A_CTRL, 32'h7030);
        wt(5'h18, 5'h00, "alarm disabled");
        apb(1'b1, A_AUXDLY, 32'h14);
        aux <= 1'b1;
        repeat (150) @(posedge clk_sys);
        chk("aux early", 32'h0, {31'h0, ao});
        for (int i = 0; i < 300 && ao !== 1'b1; i++) @(posedge clk_sys);
        chk("aux on delay", 32'h1, {31'h0, ao});
        aux <= 1'b0;
        repeat (100) @(posedge clk_sys);
        apb(1'b1, A_AUXDLY, 32'h0);
        // one wide pulse, then one too short to count
        aux <= 1'b1;
        repeat (400) @(posedge clk_sys);
        aux <= 1'b0;
        repeat (100) @(posedge clk_sys);
        aux <= 1'b1;
        repeat (100) @(posedge clk_sys);
        aux <= 1'b0;
        repeat (100) @(posedge clk_sys);
        apb(1'b0, A_PULSES, 32'h0);
        chk("pulse count", 32'h1, rd);
        apb(1'b1, A_CTRL, 32'h7230);
        repeat (2) @(posedge clk_sys);
        chk("aux telemetry", 32'h1, {31'h0, ao});
    endtask
    task results;
        if (n_fail == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_fixed();
        t_alt();
        t_fail();
        t_phase();
        t_aux();
        results();
    end
endmodule
